//--- cfg_regs_asserts.sv
// Port checker for the serial configuration register bank.
// Assumes one clock domain; bound to every instance of the top.
`timescale 1ns/1ps
`default_nettype none
module cfg_regs_asserts
   import cfg_regs_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic SERIAL_CLOCK_PIN,
   input wire logic SERIAL_DATA_PIN_OE,
   input wire pll_cfg_type PLL_CFG,
   input wire logic [5:0] OUTPUT_DRIVE_ON
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // Ack holds over the ninth pulse, then lets go
   sequence ack_pulse;
      SERIAL_DATA_PIN_OE [*6] ##[1:6] !SERIAL_DATA_PIN_OE;
   endsequence
   chk_reset_quiet: assert property (disable iff (1'b0) RST [*2] |->
      !SERIAL_DATA_PIN_OE && OUTPUT_DRIVE_ON == 6'h00) else $error("active in reset");
   chk_enable_map: assert property ($stable(PLL_CFG) [*4] |->
      OUTPUT_DRIVE_ON == PLL_CFG.output_enable_bits) else $error("enable map");
   chk_prediv_range: assert property (!RST [*3] |->
      PLL_CFG.predivide_ratio inside {[2:129]}) else $error("ratio range");
   chk_ack_hold: assert property ($rose(SERIAL_DATA_PIN_OE) |-> ack_pulse)
      else $error("ack length");
   chk_idle_quiet: assert property (SERIAL_CLOCK_PIN [*8] |-> !SERIAL_DATA_PIN_OE)
      else $error("drive while idle");
   chk_cap_ack: assert property ($changed(PLL_CFG.load_cap_code) |->
      ##[0:6] SERIAL_DATA_PIN_OE) else $error("cap without ack");
   chk_gain_ack: assert property ($changed(PLL_CFG.crystal_drive_gain) |->
      ##[0:6] SERIAL_DATA_PIN_OE) else $error("gain without ack");
   chk_drive_ack: assert property ($changed(OUTPUT_DRIVE_ON) |->
      ##[0:8] SERIAL_DATA_PIN_OE) else $error("enable without ack");
endmodule // cfg_regs_asserts
bind clock_gen_serial_config_regs cfg_regs_asserts cfg_regs_asserts_inst (.SYS_CLK, .RST,
   .SERIAL_CLOCK_PIN, .SERIAL_DATA_PIN_OE, .PLL_CFG, .OUTPUT_DRIVE_ON);
`default_nettype wire

//--- cfg_regs_pkg.sv
// Constants, field layouts and types for the serial configuration register bank.
// Assumes a single system clock domain; serial pins are sampled as ordinary inputs.
`default_nettype none
package cfg_regs_pkg;
   localparam logic [6:0] TARGET_ADDR = 7'h69;
   localparam logic [7:0] OFS_OUTPUT_ENABLE = 8'h09;
   localparam logic [7:0] OFS_BANK1 = 8'h0c;
   localparam logic [7:0] OFS_CRYSTAL_DRIVE = 8'h12;
   localparam logic [7:0] OFS_LOAD_CAP = 8'h13;
   localparam logic [7:0] OFS_PUMP_FB_HIGH = 8'h40;
   localparam logic [7:0] OFS_FB_LOW = 8'h41;
   localparam logic [7:0] OFS_ODD_PREDIV = 8'h42;
   localparam logic [7:0] OFS_XPT_A = 8'h44;
   localparam logic [7:0] OFS_XPT_B = 8'h45;
   localparam logic [7:0] OFS_XPT_C = 8'h46;
   localparam logic [7:0] OFS_BANK2 = 8'h47;
   // Fixed read-back patterns and writable masks
   localparam logic [7:0] PUMP_FIXED = 8'hc0;
   localparam logic [7:0] PUMP_MASK = 8'h1f;
   localparam logic [7:0] GAIN_FIXED = 8'h20;
   localparam logic [7:0] GAIN_MASK = 8'h18;
   localparam logic [7:0] XPT_C_FIXED = 8'h3f;
   localparam logic [7:0] XPT_C_MASK = 8'hc0;
   localparam logic [7:0] OE_MASK = 8'h3f;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [7:0] PREDIV_OFFSET = 8'h02;
   localparam int NUM_OUTPUTS = 6;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_REG = 3'b010,
      ST_DATA = 3'b011,
      ST_ACK = 3'b100,
      ST_SKIP = 3'b101
   } link_state_type;

   // Decoded configuration presented to the analog side
   typedef struct packed {
      logic [5:0] output_enable_bits;
      logic bank1_source_sel;
      logic [6:0] bank1_divide_value;
      logic bank2_source_sel;
      logic [6:0] bank2_divide_value;
      logic [1:0] crystal_drive_gain;
      logic [7:0] load_cap_code;
      logic [2:0] pump_code;
      logic [9:0] feedback_base_count;
      logic feedback_odd_bit;
      logic [7:0] predivide_ratio;
      logic [17:0] output_source_select;
   } pll_cfg_type;
endpackage
`default_nettype wire

//--- clock_gen_serial_config_regs.sv
// Serial programming target and volatile configuration register bank.
// Holds the eleven writable configuration registers and decodes them for the PLL side.
// Assumes SCL and SDA come from another domain and are oversampled by SYS_CLK.
// Assumes a pull-up on the data wire; this block only ever pulls it low.
`timescale 1ns/1ps
`default_nettype none
module clock_gen_serial_config_regs
   import cfg_regs_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic SERIAL_CLOCK_PIN,
   input wire logic SERIAL_DATA_PIN_IN,
   output logic SERIAL_DATA_PIN_OUT,
   output logic SERIAL_DATA_PIN_OE,
   output pll_cfg_type PLL_CFG,
   output logic [5:0] OUTPUT_DRIVE_ON
);
   // Synchronised pins and framing events
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic scl_prev;
   logic sda_prev;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   // Receiver, write port and register image
   link_state_type state;
   link_state_type after_ack;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [7:0] reg_ptr;
   logic ack_drive;
   logic wr_strobe;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] mem [0:255];
   logic [7:0] next_store;
   logic store_valid;
   wire logic [5:0] next_drive;

   // Two-stage synchronisers; only the second stage feeds edge logic.
   // Reset to the idle-high level so release of reset shows no false edge.
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
      end else begin
         scl_sync <= {scl_sync[0], SERIAL_CLOCK_PIN};
         sda_sync <= {sda_sync[0], SERIAL_DATA_PIN_IN};
      end
   end

   // One cycle of history on the synchronised lines for edge and framing detection
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_sync[1];
         sda_prev <= sda_sync[1];
      end
   end

   // Framing events: data moving while clock high marks start or stop
   assign scl_rise = scl_sync[1] & ~scl_prev;
   assign scl_fall = ~scl_sync[1] & scl_prev;
   assign start_seen = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
   assign stop_seen = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

   // Byte receiver and acknowledge sequencer; target only, never masters
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state <= ST_IDLE;
         after_ack <= ST_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         reg_ptr <= 8'h00;
         ack_drive <= 1'b0;
         wr_strobe <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         wr_strobe <= 1'b0;
         // A start anywhere restarts address matching; a stop abandons the frame
         if (start_seen) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            ack_drive <= 1'b0;
         end else if (stop_seen) begin
            state <= ST_IDLE;
            ack_drive <= 1'b0;
         end else begin
            case (state)
               ST_ADDR, ST_REG, ST_DATA: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_sync[1]};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     bit_cnt <= 4'h0;
                     // Only a write to our address is acknowledged; reads get no ack
                     if (state == ST_ADDR) begin
                        if (shift == {TARGET_ADDR, 1'b0}) begin
                           ack_drive <= 1'b1;
                           after_ack <= ST_REG;
                           state <= ST_ACK;
                        end else begin
                           state <= ST_SKIP;
                        end
                     end else if (state == ST_REG) begin
                        reg_ptr <= shift;
                        ack_drive <= 1'b1;
                        after_ack <= ST_DATA;
                        state <= ST_ACK;
                     end else begin
                        wr_strobe <= 1'b1;
                        wr_addr <= reg_ptr;
                        wr_data <= shift;
                        reg_ptr <= reg_ptr + 8'h01; // Burst writes advance the pointer
                        ack_drive <= 1'b1;
                        after_ack <= ST_DATA;
                        state <= ST_ACK;
                     end
                  end
               end
               ST_ACK: begin
                  // Release the line on the falling edge closing the ack bit
                  if (scl_fall) begin
                     ack_drive <= 1'b0;
                     state <= after_ack;
                  end
               end
               ST_SKIP: state <= ST_SKIP;
               ST_IDLE: state <= ST_IDLE;
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // Open-drain data pin: drive low only during our acknowledge
   // The value flop stays at zero; only the enable moves, so no high is ever driven
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         SERIAL_DATA_PIN_OUT <= 1'b0;
         SERIAL_DATA_PIN_OE <= 1'b0;
      end else begin
         SERIAL_DATA_PIN_OUT <= 1'b0;
         SERIAL_DATA_PIN_OE <= ack_drive;
      end
   end

   // Byte to store for the addressed register: host bits under the writable mask,
   // fixed bits forced, so the image always follows the register layout
   always_comb begin
      next_store = wr_data;
      store_valid = 1'b1;
      case (wr_addr)
         OFS_OUTPUT_ENABLE: next_store = wr_data & OE_MASK;
         OFS_CRYSTAL_DRIVE: next_store = (wr_data & GAIN_MASK) | GAIN_FIXED;
         OFS_PUMP_FB_HIGH: next_store = (wr_data & PUMP_MASK) | PUMP_FIXED;
         OFS_XPT_C: next_store = (wr_data & XPT_C_MASK) | XPT_C_FIXED;
         OFS_BANK1, OFS_BANK2, OFS_LOAD_CAP, OFS_FB_LOW, OFS_ODD_PREDIV,
         OFS_XPT_A, OFS_XPT_B: next_store = wr_data;
         // Reserved addresses are dropped rather than corrupting state
         default: store_valid = 1'b0;
      endcase
   end

   // Volatile register array; reset stands in for power-up to blank state
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < 256; i++) begin
            mem[i] <= RESET_VALUE;
         end
      end else if (wr_strobe && store_valid) begin
         mem[wr_addr] <= next_store;
      end
   end

   // Field decode toward the analog side, registered so outputs are flops
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         PLL_CFG <= '0;
      end else begin
         // Output enables and the two post-divider banks
         PLL_CFG.output_enable_bits <= mem[OFS_OUTPUT_ENABLE][5:0];
         PLL_CFG.bank1_source_sel <= mem[OFS_BANK1][7];
         PLL_CFG.bank1_divide_value <= mem[OFS_BANK1][6:0];
         PLL_CFG.bank2_source_sel <= mem[OFS_BANK2][7];
         PLL_CFG.bank2_divide_value <= mem[OFS_BANK2][6:0];
         // Oscillator drive and load capacitance
         PLL_CFG.crystal_drive_gain <= mem[OFS_CRYSTAL_DRIVE][4:3];
         PLL_CFG.load_cap_code <= mem[OFS_LOAD_CAP];
         // Feedback and reference counters with the pump code
         PLL_CFG.pump_code <= mem[OFS_PUMP_FB_HIGH][4:2];
         PLL_CFG.feedback_base_count <= {mem[OFS_PUMP_FB_HIGH][1:0], mem[OFS_FB_LOW]};
         PLL_CFG.feedback_odd_bit <= mem[OFS_ODD_PREDIV][7];
         PLL_CFG.predivide_ratio <= {1'b0, mem[OFS_ODD_PREDIV][6:0]} + PREDIV_OFFSET;
         // Crosspoint selects, first output in the top bits
         PLL_CFG.output_source_select <= {mem[OFS_XPT_A], mem[OFS_XPT_B],
                                          mem[OFS_XPT_C][7:6]};
      end
   end

   // Per-output enable: a one turns its driver on, a zero leaves it off
   for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_drive
      assign next_drive[g] = mem[OFS_OUTPUT_ENABLE][g];
   end

   // Driver enables registered so the pins never glitch; blank part is all off
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         OUTPUT_DRIVE_ON <= 6'h00;
      end else begin
         OUTPUT_DRIVE_ON <= next_drive;
      end
   end
endmodule // clock_gen_serial_config_regs
`default_nettype wire

//--- clock_gen_serial_config_regs_tb.sv
// Self-checking bench for the serial configuration register bank.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module clock_gen_serial_config_regs_tb;
   import cfg_regs_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic scl, sda_drv, dut_out, dut_oe;
   logic [5:0] drive_on;
   logic [2:0] acks;
   pll_cfg_type cfg, exp;
   wire logic sda;
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [7:0] ofs_t [11] = '{8'h09, 8'h0c, 8'h12, 8'h13, 8'h40, 8'h41, 8'h42, 8'h44, 8'h45,
      8'h46, 8'h47};
   // Crystal setup: 25-30 MHz, 60 ohm, middle load band, so gain 11 and ratio 16
   logic [7:0] dat_t [11] = '{8'h3f, 8'h85, 8'h38, 8'ha5, 8'hdb, 8'h5a, 8'h8e, 8'h96, 8'h3c,
      8'h7f, 8'h04};
   // Pull-up wire: whoever pulls low wins
   assign sda = sda_drv & ~(dut_oe & ~dut_out);
   always #12.5 sys_clk = ~sys_clk;
   serial_host serial_host_inst (.scl(scl), .sda_drv(sda_drv), .sda(sda));
   clock_gen_serial_config_regs clock_gen_serial_config_regs_inst (.SYS_CLK(sys_clk),
      .RST(rst), .SERIAL_CLOCK_PIN(scl), .SERIAL_DATA_PIN_IN(sda), .SERIAL_DATA_PIN_OUT(dut_out),
      .SERIAL_DATA_PIN_OE(dut_oe), .PLL_CFG(cfg), .OUTPUT_DRIVE_ON(drive_on));
   task automatic check(input string what, input logic [71:0] seen, want);
      tests_run++;
      if (seen !== want) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic finish_test();
      $display("Checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] dev, ofs, d, input logic [2:0] want);
      serial_host_inst.frame(dev, ofs, d, acks);
      @(negedge sys_clk);
      check("acks", 72'(acks), 72'(want));
   endtask
   // Each frame is about 230 cycles; this run needs some 4200
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      exp = '0;
      exp.predivide_ratio = 8'h02;
      check("blank", cfg, exp);
      $display("Test blank done");
      foreach (ofs_t[i]) wr(8'hd2, ofs_t[i], dat_t[i], 3'b111);
      exp = '{6'h3f, 1'b1, 7'h05, 1'b0, 7'h04, 2'b11, 8'ha5, 3'b110, 10'h35a, 1'b1, 8'h10,
         {8'h96, 8'h3c, 2'b01}};
      check("fields", cfg, exp);
      check("drive", 72'(drive_on), 72'h3f);
      $display("Test all registers done");
      wr(8'hd3, 8'h13, 8'h00, 3'b000);
      wr(8'hd0, 8'h13, 8'h00, 3'b000);
      wr(8'hd2, 8'h43, 8'h55, 3'b111);
      check("ignored", cfg, exp);
      $display("Test refused writes done");
      // Driven reference of 50-90 MHz: gain 10, no load code, widest predivide
      wr(8'hd2, 8'h12, 8'h30, 3'b111);
      wr(8'hd2, 8'h13, 8'h00, 3'b111);
      wr(8'hd2, 8'h42, 8'h7f, 3'b111);
      exp.crystal_drive_gain = 2'b10;
      exp.load_cap_code = 8'h00;
      exp.feedback_odd_bit = 1'b0;
      exp.predivide_ratio = 8'h81;
      check("driven ref", cfg, exp);
      $display("Test driven reference done");
      wr(8'hd2, 8'h09, 8'h15, 3'b111);
      check("drive odd", 72'(drive_on), 72'h15);
      $display("Test enables done");
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      check("in reset", 72'(drive_on), 72'h00);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      exp = '0;
      exp.predivide_ratio = 8'h02;
      check("reblank", cfg, exp);
      $display("Test reset done");
      finish_test();
   end
endmodule // clock_gen_serial_config_regs_tb
`default_nettype wire

//--- serial_host.sv
// Host model driving the two-wire programming link.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module serial_host (
   output logic scl,
   output logic sda_drv,
   input wire logic sda
);
   // Clock stands high between frames, data released
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // Data moves mid-low so it is steady across the high phase
   task automatic put_bit(input logic b, output logic seen);
      #50 sda_drv = b;
      #50 scl = 1'b1;
      #50 seen = sda;
      #50 scl = 1'b0;
   endtask
   // Msb first, then release the wire for the target's ack
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(b[i], s);
      put_bit(1'b1, s);
      ack = ~s;
   endtask
   task automatic frame(input logic [7:0] dev, ofs, d, output logic [2:0] acks);
      #100 sda_drv = 1'b0; // Start: data falls, clock high
      #100 scl = 1'b0;
      put_byte(dev, acks[2]);
      put_byte(ofs, acks[1]);
      put_byte(d, acks[0]);
      #50 sda_drv = 1'b0;
      #50 scl = 1'b1;
      #100 sda_drv = 1'b1; // Stop ends the frame
   endtask
endmodule // serial_host
`default_nettype wire
